// ===== hdl/fic_pkg.sv
package fic_pkg;
    // Register offsets in data sector 0
    localparam logic [7:0] FIC_OFS_CTRL     = 8'h50;
    localparam logic [7:0] FIC_OFS_RSTPAT   = 8'h51;
    localparam logic [7:0] FIC_OFS_BUFCLR   = 8'h52;
    localparam logic [7:0] FIC_OFS_ADDR_LO  = 8'h53;
    localparam logic [7:0] FIC_OFS_ADDR_HI  = 8'h54;
    localparam logic [7:0] FIC_OFS_DATA0_LO = 8'h55;
    // Control register field positions
    localparam int FIC_BIT_WEN_STAT = 7;
    localparam int FIC_BIT_MODE_HI  = 6;
    localparam int FIC_BIT_MODE_LO  = 4;
    localparam int FIC_BIT_UNLK_EN  = 3;
    localparam int FIC_BIT_WR_INIT  = 2;
    localparam int FIC_BIT_RD_EN    = 1;
    localparam int FIC_BIT_RD_INIT  = 0;
    localparam logic [7:0] FIC_CTRL_RESET = 8'h70;
    localparam logic [7:0] FIC_BYTE_RESET = 8'h00;
    // Operation mode codes
    localparam logic [2:0] FIC_MODE_WRITE  = 3'h0;
    localparam logic [2:0] FIC_MODE_ERASE  = 3'h1;
    localparam logic [2:0] FIC_MODE_READ   = 3'h3;
    localparam logic [2:0] FIC_MODE_UNLOCK = 3'h6;
    localparam logic [7:0] FIC_CHIP_RST_PAT = 8'h55;
    // Unlock pattern, bytes into data words 1..3 low/high
    localparam logic [47:0] FIC_UNLOCK_PAT = 48'h40C3_090D_0400;
    // Unlock window in microseconds, counted on the low-speed oscillator
    localparam int FIC_UNLOCK_US = 300;
    localparam int FIC_OSC_KHZ   = 32;
    localparam int FIC_UNLOCK_TICKS = (FIC_UNLOCK_US * FIC_OSC_KHZ) / 1000;
    // Variant: 0 small, 1 mid, 2 large
    localparam int FIC_ERASE_WORDS_SMALL = 256;
    localparam int FIC_WRITE_WORDS_SMALL = 4;
    localparam int FIC_PAGE_WORDS_MID    = 32;
    localparam int FIC_PAGE_WORDS_LARGE  = 64;
    typedef enum logic [1:0] {FIC_OP_READ, FIC_OP_WRITE, FIC_OP_ERASE, FIC_OP_CLEAR} fic_op_e;
endpackage : fic_pkg

// ===== hdl/fic_flash_if.sv
`timescale 1ns/1ps
// Request/answer path between controller and its flash sequencer
interface fic_flash_if;
    logic                   req;
    fic_pkg::fic_op_e       op;
    logic [14:0]            addr;
    logic [15:0]            words;
    logic                   done;
    modport ctrl (output req, output op, output addr, output words, input done);
    modport seq  (input req, input op, input addr, input words, output done);
endinterface : fic_flash_if

// ===== hdl/fic_unlock.sv
`timescale 1ns/1ps
// Unlock window timer; counts enable ticks from the low-speed oscillator
module fic_unlock #(
    parameter int TICKS = fic_pkg::FIC_UNLOCK_TICKS
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_run,
    input  wire logic i_tick,
    output logic      o_expired
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    // Restart whenever the procedure is idle
    always_comb begin
        cnt_d = cnt_q;
        if (!i_run) begin
            cnt_d = 16'h0000;
        end else if (i_tick && (cnt_q != TICKS[15:0])) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_expired = i_run && (cnt_q == TICKS[15:0]);
endmodule : fic_unlock

// ===== hdl/fic_seq.sv
`timescale 1ns/1ps
// Flash array sequencer: holds a busy count per operation word
module fic_seq #(
    parameter int CYC_PER_WORD = 4
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    fic_flash_if.seq  bus,
    output logic      o_busy
);
    logic [19:0] cnt_q;
    logic [19:0] cnt_d;
    logic        busy_q;
    logic        busy_d;
    logic        done_q;
    logic        done_d;

    // Load on request, count down, pulse done at end
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (!busy_q && bus.req) begin
            busy_d = 1'b1;
            cnt_d  = 20'(bus.words) * 20'(CYC_PER_WORD);
        end else if (busy_q) begin
            if (cnt_q <= 20'h00001) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 20'h00001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q  <= 20'h00000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign bus.done = done_q;
    assign o_busy   = busy_q;
endmodule : fic_seq

// ===== hdl/fic_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Mode codes write, erase, read, unlock decoded
// - Erase is block on small, page otherwise
// - Erase and write sizes follow the variant
// - Write-enabled bit set by hardware only
// - Unlock runs with enable bit and mode 110
// - Write initiate cleared by hardware when done
// - Read initiate cleared by hardware when done
// - Read enable bit gates reads
// - Pattern 55H on reset register resets chip
// - Buffer clear bit cleared when clear completes
// - Address high width depends on variant
// - Four 16-bit data words as byte pairs
// - Unlock timeout, pattern check, enable cleared
module fic_top #(
    parameter int VARIANT      = 2,
    parameter int ADDR_HI_BITS = 7,
    parameter int OSC_DIV      = 1563
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RSTN,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic [15:0] I_FLASH_RDATA,
    output logic      [7:0]  O_RDATA,
    output logic             O_CHIP_RST,
    output logic      [14:0] O_FLASH_ADDR,
    output logic             O_FLASH_BUSY
);
    // Implemented high-address width: small 4, mid 5, large set by parameter
    localparam int HI_W = (VARIANT == 0) ? 4 : (VARIANT == 1) ? 5 : ADDR_HI_BITS;

    // Register image, unlock progress and operation launch state
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  rst_pat_q, rst_pat_d;
    logic        buf_clr_q, buf_clr_d;
    logic [7:0]  addr_lo_q, addr_lo_d;
    logic [6:0]  addr_hi_q, addr_hi_d;
    logic [7:0]  data_q [8];
    logic [7:0]  data_d [8];
    logic [7:0]  rdata_q, rdata_d;
    logic        chip_rst_q, chip_rst_d;
    logic        req_q, req_d;
    fic_pkg::fic_op_e op_q, op_d;
    logic        unlk_run_q, unlk_run_d;
    logic [2:0]  pat_idx_q, pat_idx_d;
    logic        pat_bad_q, pat_bad_d;
    logic [15:0] osc_cnt_q, osc_cnt_d;
    logic        osc_tick;
    logic        expired;
    logic        seq_busy;
    logic [2:0]  mode;

    fic_flash_if fbus ();

    ////////////////////////////////////////////////////////////////////////
    // Helper decoders: byte index for the write and read paths, word count for the sequencer request
    // Data-word byte index from a register offset
    function automatic logic [3:0] data_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - fic_pkg::FIC_OFS_DATA0_LO;
        data_index = (a >= fic_pkg::FIC_OFS_DATA0_LO && d < 8'h08) ? {1'b1, d[2:0]} : 4'h0;
    endfunction : data_index

    // Word count of an operation; small variant writes four, others a whole page
    function automatic logic [15:0] op_words(input fic_pkg::fic_op_e op);
        case (op)
            fic_pkg::FIC_OP_ERASE: op_words = 16'((VARIANT == 0) ? fic_pkg::FIC_ERASE_WORDS_SMALL :
                (VARIANT == 1) ? fic_pkg::FIC_PAGE_WORDS_MID : fic_pkg::FIC_PAGE_WORDS_LARGE);
            fic_pkg::FIC_OP_WRITE: op_words = 16'((VARIANT == 0) ? fic_pkg::FIC_WRITE_WORDS_SMALL :
                (VARIANT == 1) ? fic_pkg::FIC_PAGE_WORDS_MID : fic_pkg::FIC_PAGE_WORDS_LARGE);
            default:               op_words = 16'h0001;
        endcase
    endfunction : op_words

    ////////////////////////////////////////////////////////////////////////
    // Low-speed oscillator stand-in: one-cycle tick from the system clock
    // OSC_DIV sets the tick period; a short divider shortens the unlock window
    always_comb begin
        osc_cnt_d = (osc_cnt_q == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_cnt_q + 16'h0001;
    end
    assign osc_tick = (osc_cnt_q == 16'(OSC_DIV - 1));

    // Unlock window timer, running only while an unlock is in progress
    fic_unlock u_unlock (
        .i_clk     (I_REF_CLK),
        .i_rstn    (I_RSTN),
        .i_run     (unlk_run_q),
        .i_tick    (osc_tick),
        .o_expired (expired)
    );

    // Array sequencer; a buffer clear counts as a one-word operation
    fic_seq u_seq (
        .i_clk  (I_REF_CLK),
        .i_rstn (I_RSTN),
        .bus    (fbus),
        .o_busy (seq_busy)
    );

    // Request side of the sequencer link
    assign fbus.req   = req_q;
    assign fbus.op    = op_q;
    assign fbus.addr  = {addr_hi_q, addr_lo_q};
    assign fbus.words = op_words(op_q);
    // Operation mode field of the control register
    assign mode = ctrl_q[fic_pkg::FIC_BIT_MODE_HI:fic_pkg::FIC_BIT_MODE_LO];

    ////////////////////////////////////////////////////////////////////////
    // Register writes, launches and hardware completions
    always_comb begin
        logic [3:0] di;
        logic [7:0] pat_byte;
        di         = data_index(I_ADDR);
        pat_byte   = 8'h00;
        ctrl_d     = ctrl_q;
        rst_pat_d  = rst_pat_q;
        buf_clr_d  = buf_clr_q;
        addr_lo_d  = addr_lo_q;
        addr_hi_d  = addr_hi_q;
        data_d     = data_q;
        chip_rst_d = 1'b0;
        req_d      = 1'b0;
        op_d       = op_q;
        unlk_run_d = unlk_run_q;
        pat_idx_d  = pat_idx_q;
        pat_bad_d  = pat_bad_q;
        if (I_WR) begin
            case (I_ADDR)
                fic_pkg::FIC_OFS_CTRL: begin
                    // Status bit: software may only clear it
                    ctrl_d[6:0] = I_WDATA[6:0];
                    ctrl_d[fic_pkg::FIC_BIT_WEN_STAT] = ctrl_q[fic_pkg::FIC_BIT_WEN_STAT]
                        & I_WDATA[fic_pkg::FIC_BIT_WEN_STAT];
                    // A running unlock keeps its enable bit until it ends
                    if (unlk_run_q) ctrl_d[fic_pkg::FIC_BIT_UNLK_EN] = 1'b1;
                    // An operation in flight keeps its initiate bits: only its
                    // completion clears them, so a poll never reads idle early
                    if (req_q || seq_busy) begin
                        ctrl_d[fic_pkg::FIC_BIT_WR_INIT] = ctrl_q[fic_pkg::FIC_BIT_WR_INIT]
                            | I_WDATA[fic_pkg::FIC_BIT_WR_INIT];
                        ctrl_d[fic_pkg::FIC_BIT_RD_INIT] = ctrl_q[fic_pkg::FIC_BIT_RD_INIT]
                            | I_WDATA[fic_pkg::FIC_BIT_RD_INIT];
                    end
                end
                fic_pkg::FIC_OFS_RSTPAT: begin
                    // Any other value is only stored
                    rst_pat_d  = I_WDATA;
                    chip_rst_d = (I_WDATA == fic_pkg::FIC_CHIP_RST_PAT);
                end
                fic_pkg::FIC_OFS_BUFCLR: begin
                    // Software can only set the bit; the small variant has no buffer
                    if (VARIANT != 0) buf_clr_d = buf_clr_q | I_WDATA[0];
                end
                fic_pkg::FIC_OFS_ADDR_LO: addr_lo_d = I_WDATA;
                // Bits beyond the variant's width are dropped and read as zero
                fic_pkg::FIC_OFS_ADDR_HI: addr_hi_d = 7'(I_WDATA[HI_W-1:0]);
                default: begin
                    if (di[3]) begin
                        data_d[di[2:0]] = I_WDATA;
                        // Pattern bytes counted in data words 1..3
                        // A byte at the wrong place or of the wrong value fails it
                        if (unlk_run_q && di[2:1] != 2'b00) begin
                            pat_byte = fic_pkg::FIC_UNLOCK_PAT[8*pat_idx_q +: 8];
                            if (di[2:0] != 3'(pat_idx_q + 3'h2) || I_WDATA != pat_byte)
                                pat_bad_d = 1'b1;
                            pat_idx_d = pat_idx_q + 3'h1;
                        end
                    end
                end
            endcase
        end
        // Unlock start with enable bit and unlock mode
        // It then runs until six bytes, a wrong byte or the timeout end it
        if (!unlk_run_q && ctrl_q[fic_pkg::FIC_BIT_UNLK_EN] && mode == fic_pkg::FIC_MODE_UNLOCK) begin
            unlk_run_d = 1'b1;
            pat_idx_d  = 3'h0;
            pat_bad_d  = 1'b0;
        end else if (unlk_run_q && (expired || pat_bad_q || pat_idx_q == 3'h6)) begin
            unlk_run_d = 1'b0;
            ctrl_d[fic_pkg::FIC_BIT_UNLK_EN] = 1'b0;
            if (!expired && !pat_bad_q)
                ctrl_d[fic_pkg::FIC_BIT_WEN_STAT] = 1'b1;
        end
        // Launch one operation when the sequencer is idle. The done pulse
        // comes in the first idle cycle, while the initiate bit still stands;
        // launching then would run the finished operation a second time.
        // Read goes first, then write or erase, then buffer clear.
        if (!seq_busy && !req_q && !fbus.done) begin
            if (ctrl_q[fic_pkg::FIC_BIT_RD_INIT]) begin
                if (ctrl_q[fic_pkg::FIC_BIT_RD_EN] && mode == fic_pkg::FIC_MODE_READ) begin
                    req_d = 1'b1;
                    op_d  = fic_pkg::FIC_OP_READ;
                end else begin
                    ctrl_d[fic_pkg::FIC_BIT_RD_INIT] = 1'b0;
                end
            end else if (ctrl_q[fic_pkg::FIC_BIT_WR_INIT]) begin
                if (ctrl_q[fic_pkg::FIC_BIT_WEN_STAT] && mode == fic_pkg::FIC_MODE_WRITE) begin
                    req_d = 1'b1;
                    op_d  = fic_pkg::FIC_OP_WRITE;
                end else if (ctrl_q[fic_pkg::FIC_BIT_WEN_STAT] && mode == fic_pkg::FIC_MODE_ERASE) begin
                    req_d = 1'b1;
                    op_d  = fic_pkg::FIC_OP_ERASE;
                end else begin
                    ctrl_d[fic_pkg::FIC_BIT_WR_INIT] = 1'b0;
                end
            end else if (buf_clr_q) begin
                req_d = 1'b1;
                op_d  = fic_pkg::FIC_OP_CLEAR;
            end
        end
        // Completion clears the matching initiate bit; a read also lands
        // the array word in data word zero, low byte first
        if (fbus.done) begin
            case (op_q)
                fic_pkg::FIC_OP_READ: begin
                    ctrl_d[fic_pkg::FIC_BIT_RD_INIT] = 1'b0;
                    data_d[0] = I_FLASH_RDATA[7:0];
                    data_d[1] = I_FLASH_RDATA[15:8];
                end
                fic_pkg::FIC_OP_CLEAR: begin
                    // A fresh request written in the same cycle survives
                    buf_clr_d = I_WR && (I_ADDR == fic_pkg::FIC_OFS_BUFCLR)
                        && I_WDATA[0] && (VARIANT != 0);
                end
                default: ctrl_d[fic_pkg::FIC_BIT_WR_INIT] = 1'b0;
            endcase
        end
    end

    // Read mux; unimplemented high-address bits read as zero
    // Registered, so data stands from the cycle after the read strobe
    always_comb begin
        logic [3:0] ri;
        ri      = data_index(I_ADDR);
        rdata_d = rdata_q;
        if (I_RD) begin
            case (I_ADDR)
                fic_pkg::FIC_OFS_CTRL:    rdata_d = ctrl_q;
                fic_pkg::FIC_OFS_RSTPAT:  rdata_d = rst_pat_q;
                fic_pkg::FIC_OFS_BUFCLR:  rdata_d = {7'h00, buf_clr_q};
                fic_pkg::FIC_OFS_ADDR_LO: rdata_d = addr_lo_q;
                fic_pkg::FIC_OFS_ADDR_HI: rdata_d = {1'b0, addr_hi_q};
                default:                  rdata_d = ri[3] ? data_q[ri[2:0]] : 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    // Only constants under reset; next values come from the processes above
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q     <= fic_pkg::FIC_CTRL_RESET;
            rst_pat_q  <= fic_pkg::FIC_BYTE_RESET;
            buf_clr_q  <= 1'b0;
            addr_lo_q  <= fic_pkg::FIC_BYTE_RESET;
            addr_hi_q  <= 7'h00;
            for (int i = 0; i < 8; i++) data_q[i] <= fic_pkg::FIC_BYTE_RESET;
            rdata_q    <= fic_pkg::FIC_BYTE_RESET;
            chip_rst_q <= 1'b0;
            req_q      <= 1'b0;
            op_q       <= fic_pkg::FIC_OP_READ;
            unlk_run_q <= 1'b0;
            pat_idx_q  <= 3'h0;
            pat_bad_q  <= 1'b0;
            osc_cnt_q  <= 16'h0000;
        end else begin
            ctrl_q     <= ctrl_d;
            rst_pat_q  <= rst_pat_d;
            buf_clr_q  <= buf_clr_d;
            addr_lo_q  <= addr_lo_d;
            addr_hi_q  <= addr_hi_d;
            data_q     <= data_d;
            rdata_q    <= rdata_d;
            chip_rst_q <= chip_rst_d;
            req_q      <= req_d;
            op_q       <= op_d;
            unlk_run_q <= unlk_run_d;
            pat_idx_q  <= pat_idx_d;
            pat_bad_q  <= pat_bad_d;
            osc_cnt_q  <= osc_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs taken straight from registers
    assign O_RDATA      = rdata_q;
    assign O_CHIP_RST   = chip_rst_q;
    assign O_FLASH_ADDR = {addr_hi_q, addr_lo_q};
    assign O_FLASH_BUSY = seq_busy;
endmodule : fic_top

// ===== bench/fic_chk_properties.sv
`timescale 1ns/1ps
// Port-level checker for the flash access controller
module fic_chk #(
    parameter int ADDR_HI_BITS = 7
) (
    input wire logic        I_REF_CLK,
    input wire logic        I_RSTN,
    input wire logic [7:0]  I_ADDR,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [7:0]  I_WDATA,
    input wire logic [15:0] I_FLASH_RDATA,
    input wire logic [7:0]  O_RDATA,
    input wire logic        O_CHIP_RST,
    input wire logic [14:0] O_FLASH_ADDR,
    input wire logic        O_FLASH_BUSY
);
    // Implemented high address bits; upper ones must read back zero
    localparam logic [6:0] HI_MASK = 7'h7F >> (7 - ADDR_HI_BITS);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RSTN);
    logic wr_ctrl;
    logic wr_pat;
    // Decoded strobes shared by several properties
    assign wr_ctrl = I_WR && (I_ADDR == fic_pkg::FIC_OFS_CTRL);
    assign wr_pat  = I_WR && (I_ADDR == fic_pkg::FIC_OFS_RSTPAT)
                     && (I_WDATA == fic_pkg::FIC_CHIP_RST_PAT);
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst_after_pat; wr_pat |=> O_CHIP_RST; endproperty
    a_rst_after_pat: assert property (p_rst_after_pat)
        else $error("chip reset pulse missing after pattern write");
    property p_rst_one; O_CHIP_RST |=> !O_CHIP_RST; endproperty
    a_rst_one: assert property (p_rst_one)
        else $error("chip reset pulse longer than one cycle");
    property p_rst_cause; O_CHIP_RST |-> $past(wr_pat); endproperty
    a_rst_cause: assert property (p_rst_cause)
        else $error("chip reset pulse without pattern write");
    property p_rdata_hold; !I_RD |=> $stable(O_RDATA); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    property p_unmapped; I_RD && (I_ADDR == 8'h60) |=> (O_RDATA == 8'h00); endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    ////////////////////////////////////////////////////////////////////////////////
    property p_read_span;
        wr_ctrl && (I_WDATA == 8'h33) && !O_FLASH_BUSY
            |-> ##3 O_FLASH_BUSY [*4] ##1 !O_FLASH_BUSY;
    endproperty
    a_read_span: assert property (p_read_span)
        else $error("one-word read busy span wrong");
    property p_read_gate;
        wr_ctrl && (I_WDATA == 8'h31) && !O_FLASH_BUSY |=> !O_FLASH_BUSY [*4];
    endproperty
    a_read_gate: assert property (p_read_gate)
        else $error("read ran with read enable low");
    property p_busy_cause;
        $rose(O_FLASH_BUSY)
            |-> $past(I_WR && ((I_ADDR == fic_pkg::FIC_OFS_CTRL)
                               || (I_ADDR == fic_pkg::FIC_OFS_BUFCLR)), 3);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without an initiating write");
    property p_addr_lo;
        I_WR && (I_ADDR == fic_pkg::FIC_OFS_ADDR_LO) |=> (O_FLASH_ADDR[7:0] == $past(I_WDATA));
    endproperty
    a_addr_lo: assert property (p_addr_lo)
        else $error("flash address low byte not taken");
    property p_addr_hi;
        I_WR && (I_ADDR == fic_pkg::FIC_OFS_ADDR_HI)
            |=> (O_FLASH_ADDR[14:8] == ($past(I_WDATA[6:0]) & HI_MASK));
    endproperty
    a_addr_hi: assert property (p_addr_hi)
        else $error("flash address high byte wrong");
endmodule : fic_chk

// ===== bench/fic_flash_model.sv
`timescale 1ns/1ps
// Flash array stand-in: addressed word appears one cycle after the address
module fic_flash_model (
    input  wire logic        i_clk,
    input  wire logic [14:0] i_addr,
    output logic      [15:0] o_rdata
);
    // Scrambled contents so address faults show up as data faults
    always_ff @(posedge i_clk) begin
        o_rdata <= {1'b1, i_addr} ^ 16'hC35A;
    end
endmodule : fic_flash_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [15:0] frdata;
    logic [7:0]  rdata;
    logic        chip_rst;
    logic [14:0] faddr;
    logic        busy;
    int          n_errors = 0;
    int          total_checks = 0;
    int          busy_cnt = 0;
    int          rst_cnt = 0;
    logic [2:0]  rsv [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
    always #10 clk = ~clk;
    fic_top #(.VARIANT(2), .ADDR_HI_BITS(7), .OSC_DIV(4)) uut (
        .I_REF_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WDATA(wdata), .I_FLASH_RDATA(frdata), .O_RDATA(rdata),
        .O_CHIP_RST(chip_rst), .O_FLASH_ADDR(faddr), .O_FLASH_BUSY(busy));
    fic_flash_model u_flash (.i_clk(clk), .i_addr(faddr), .o_rdata(frdata));
    // Cycle counts of busy and reset pulses, sampled on the edge
    always @(posedge clk) begin
        if (busy === 1'b1) busy_cnt++;
        if (chip_rst === 1'b1) rst_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 begin addr = a; wdata = d; wr = 1'b1; end
        @(posedge clk) #1 wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1 begin addr = a; rd = 1'b1; end
        @(posedge clk) #1 rd = 1'b0;
        d = rdata;
    endtask : rd_reg
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d & mask});
    endtask : chk_rd
    // Bounded wait for hardware to clear an initiate bit
    task automatic poll(input logic [7:0] a, input logic [7:0] mask);
        logic [7:0] d;
        d = mask;
        for (int i = 0; i < 400 && (d & mask) !== 8'h00; i++) rd_reg(a, d);
        chk("initiate clear", 16'h0000, {8'h00, d & mask});
    endtask : poll
    task automatic op(input logic [7:0] a, input logic [7:0] d, input int exp_busy);
        busy_cnt = 0;
        wr_reg(a, d);
        poll(a, (a == fic_pkg::FIC_OFS_CTRL) ? 8'h05 : 8'h01);
        chk("busy cycles", 16'(exp_busy), 16'(busy_cnt));
    endtask : op
    task automatic unlock(input logic [47:0] pat);
        wr_reg(fic_pkg::FIC_OFS_CTRL, 8'h68);
        for (int i = 0; i < 6; i++) wr_reg(8'h57 + 8'(i), pat[8*i +: 8]);
    endtask : unlock
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    // Main sequence: reset values, registers, locked ops, unlock, ops
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        chk_rd(fic_pkg::FIC_OFS_CTRL, 8'hFF, fic_pkg::FIC_CTRL_RESET);
        for (int a = 8'h51; a <= 8'h5C; a++) chk_rd(8'(a), 8'hFF, 8'h00);
        chk_rd(8'h60, 8'hFF, 8'h00);
        wr_reg(fic_pkg::FIC_OFS_ADDR_LO, 8'hA5);
        wr_reg(fic_pkg::FIC_OFS_ADDR_HI, 8'hFF);
        chk_rd(fic_pkg::FIC_OFS_ADDR_HI, 8'hFF, 8'h7F);
        chk("flash addr", 16'h7FA5, {1'b0, faddr});
        for (int i = 0; i < 8; i++) wr_reg(8'h55 + 8'(i), 8'h11 * 8'(i + 1));
        for (int i = 0; i < 8; i++) chk_rd(8'h55 + 8'(i), 8'hFF, 8'h11 * 8'(i + 1));
        wr_reg(fic_pkg::FIC_OFS_CTRL, 8'hF0);
        chk_rd(fic_pkg::FIC_OFS_CTRL, 8'h80, 8'h00);
        op(fic_pkg::FIC_OFS_CTRL, 8'h04, 0);
        op(fic_pkg::FIC_OFS_CTRL, 8'h14, 0);
        op(fic_pkg::FIC_OFS_CTRL, 8'h31, 0);
        wr_reg(fic_pkg::FIC_OFS_ADDR_LO, 8'h34);
        wr_reg(fic_pkg::FIC_OFS_ADDR_HI, 8'h12);
        op(fic_pkg::FIC_OFS_CTRL, 8'h33, 4);
        chk_rd(fic_pkg::FIC_OFS_DATA0_LO, 8'hFF, 8'h6E);
        chk_rd(8'h56, 8'hFF, 8'h51);
        unlock(fic_pkg::FIC_UNLOCK_PAT ^ 48'h1);
        chk_rd(fic_pkg::FIC_OFS_CTRL, 8'h88, 8'h00);
        wr_reg(fic_pkg::FIC_OFS_CTRL, 8'h68);
        repeat (100) @(posedge clk);
        chk_rd(fic_pkg::FIC_OFS_CTRL, 8'h88, 8'h00);
        unlock(fic_pkg::FIC_UNLOCK_PAT);
        chk_rd(fic_pkg::FIC_OFS_CTRL, 8'h88, 8'h80);
        // Status bit must be written back as 1, or the unlock is lost
        op(fic_pkg::FIC_OFS_CTRL, 8'h94, fic_pkg::FIC_PAGE_WORDS_LARGE * 4);
        op(fic_pkg::FIC_OFS_CTRL, 8'h84, fic_pkg::FIC_PAGE_WORDS_LARGE * 4);
        for (int i = 0; i < 4; i++) op(fic_pkg::FIC_OFS_CTRL, {1'b1, rsv[i], 4'h4}, 0);
        op(fic_pkg::FIC_OFS_BUFCLR, 8'h01, 4);
        chk_rd(fic_pkg::FIC_OFS_BUFCLR, 8'hFF, 8'h00);
        wr_reg(fic_pkg::FIC_OFS_CTRL, 8'h00);
        chk_rd(fic_pkg::FIC_OFS_CTRL, 8'h80, 8'h00);
        op(fic_pkg::FIC_OFS_CTRL, 8'h04, 0);
        rst_cnt = 0;
        wr_reg(fic_pkg::FIC_OFS_RSTPAT, 8'h54);
        wr_reg(fic_pkg::FIC_OFS_RSTPAT, fic_pkg::FIC_CHIP_RST_PAT);
        repeat (3) @(posedge clk);
        chk("chip reset pulses", 16'h0001, 16'(rst_cnt));
        print_verdict();
    end
endmodule : tb_top
bind fic_top fic_chk #(.ADDR_HI_BITS(ADDR_HI_BITS)) u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
    .I_WDATA(I_WDATA), .I_FLASH_RDATA(I_FLASH_RDATA), .O_RDATA(O_RDATA),
    .O_CHIP_RST(O_CHIP_RST), .O_FLASH_ADDR(O_FLASH_ADDR), .O_FLASH_BUSY(O_FLASH_BUSY));
